// [logic/uftc_top.sv]
// Purpose: uart frame format, enable/disable, fractional baud generator and transmitter path behind apb
// Assumes: 20 MHz clk, apb master on the same clock, divider programmed to at least 2
// Notes: receiver recovery is absent; its flags only follow enable and disable
`timescale 1ns/1ns
`default_nettype none
`include "uftc_params.svh"

// Function
// - each bit time adds modulation to accumulator; carry into bit 3 adds a clock.
// - bit period is divider plus modulation over eight clocks.
// - nrz frame: start, eight or nine data bits, one or two two_stop_select.
// - parity even, odd, mark, space or off via enable and two-bit type.
// - reset format is 8 data bits, no parity, one stop bit.
// - one shared 16-bit baud generator and format; data goes lsb first.
// - with enables set pins are serial out and in; tx idles high.
// - clearing global enable releases both pins for shared use.
// - disable flushes buffer, clears enables and rx flags, sets empty and idle flags.
// - control bits other than the enables and break, and divider settings, survive a disable.
// - clearing global enable mid-frame two_stop_select everything at once.
// - stop bit count applies to transmit only; receiver checks one stop.
// - with address detect on, the top data bit marks address or data.
// - layouts 8, 7+parity, 7+address; 9, 8+parity, 8+address.
// - in nine-bit mode the ninth bit comes from a control bit.
// - shift register reloads only after previous stop bit, from waiting data.
// - sending needs transmit enable, loaded data and a running baud clock.
// - clearing transmit enable aborts the frame and releases the pin.
// - data register writes are blocked while the empty flag is zero.
// - empty flag means data register free; with its enable it raises the interrupt.
// - write while idle loads shifter, starts, sets empty; else held until frame end.
// - idle flag sets when a frame finishes after its stop bits.
module uftc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_out,
	output logic tx_oe,
	output logic rx_pin_claim,
	output logic uart_irq
);

	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl3_q;
	logic [7:0] fifoctl_q;
	logic [7:0] divh_q;
	logic [7:0] divl_q;
	logic [7:0] hold_q;
	logic hold_full_q;
	logic hold_nine_q;
	logic tx_empty_q;
	logic tx_idle_q;
	logic rx_idle_q;
	logic arm_q;
	uftc_pkg::uftc_tx_state_t st_q;
	uftc_pkg::uftc_frame_t frm_q;
	logic [3:0] bit_idx_q;
	logic [15:0] cnt_q;
	logic [3:0] acc_q;
	logic stop2_q;

	logic wr_acc;
	logic rd_acc;
	logic acc_ok;
	logic enabled;
	logic tx_run;
	logic data_wr;
	logic data_take;
	logic status_rd;
	logic bit_end;
	logic frame_done;
	logic load_now;
	logic [8:0] load_data;
	logic [3:0] load_bits;
	logic [15:0] divider;
	logic [2:0] modv;
	logic [3:0] acc_sum;
	logic [31:0] rd_mux;
	logic bit_step;
	logic last_data;

	// parity over the data bits below the parity slot
	function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic [1:0] typ);
		logic x;
		x = nine ? ^d[7:0] : ^d[6:0];
		case (typ)
			2'b00: par_bit = x;
			2'b01: par_bit = ~x;
			2'b10: par_bit = 1'b1;
			default: par_bit = 1'b0;
		endcase
	endfunction

	// apb decode; answers in the access cycle, never waits
	assign acc_ok = psel && penable;
	assign wr_acc = acc_ok && pwrite;
	assign rd_acc = acc_ok && !pwrite;
	assign enabled = ctrl1_q[`UFTC_C1_EN];
	assign tx_run = enabled && ctrl2_q[`UFTC_C2_TRANSMIT_ENABLE];
	assign data_wr = wr_acc && (paddr == `UFTC_OFF_DATA);
	assign status_rd = rd_acc && (paddr == `UFTC_OFF_STATUS);
	// blocked unless the empty flag is set
	assign data_take = data_wr && tx_empty_q && enabled;
	assign divider = {divh_q, divl_q};
	assign modv = fifoctl_q[`UFTC_FC_MOD_HI:`UFTC_FC_MOD_LO];
	assign acc_sum = acc_q + {1'b0, modv};
	assign bit_end = (st_q != uftc_pkg::TX_IDLE) && (cnt_q == `UFTC_ONE16);
	assign frame_done = bit_end && (st_q == uftc_pkg::TX_STOP) && !stop2_q;
	// one bit time over; a fresh load takes priority over stepping
	assign bit_step = tx_run && bit_end && !load_now;
	assign last_data = (bit_idx_q + `UFTC_ONE4) == frm_q.nbits;

	// ninth bit from control, parity or address occupies the top slot
	always_comb begin
		load_data = {1'b0, hold_q}; // address mark goes out as written
		load_bits = ctrl1_q[`UFTC_C1_NINE] ? `UFTC_BITS_8N1 : `UFTC_BITS_8;
		if (ctrl1_q[`UFTC_C1_NINE]) begin
			load_data[8] = hold_nine_q;
			if (ctrl1_q[`UFTC_C1_PAREN]) begin
				load_data[8] = par_bit(load_data, 1'b1, ctrl1_q[`UFTC_C1_PTYP_HI:`UFTC_C1_PTYP_LO]);
			end
		end else if (ctrl1_q[`UFTC_C1_PAREN]) begin
			load_data[7] = par_bit(load_data, 1'b0, ctrl1_q[`UFTC_C1_PTYP_HI:`UFTC_C1_PTYP_LO]);
		end
	end

	// shifter loads when idle or right after the last stop bit
	assign load_now = tx_run && hold_full_q && (st_q == uftc_pkg::TX_IDLE || frame_done);

	// control registers; disable clears only enables and break
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_q <= `UFTC_RST_BYTE;
			ctrl2_q <= `UFTC_RST_BYTE;
			ctrl3_q <= `UFTC_RST_BYTE;
			fifoctl_q <= `UFTC_RST_BYTE;
			divh_q <= `UFTC_RST_BYTE;
			divl_q <= `UFTC_RST_BYTE;
		end else begin
			if (wr_acc) begin
				case (paddr)
					`UFTC_OFF_CTRL1: ctrl1_q <= pwdata[7:0];
					`UFTC_OFF_CTRL2: ctrl2_q <= pwdata[7:0];
					`UFTC_OFF_CTRL3: ctrl3_q <= {7'h00, pwdata[0]};
					`UFTC_OFF_FIFOCTL: fifoctl_q <= {2'b00, pwdata[5:0]};
					`UFTC_OFF_DIVH: divh_q <= pwdata[7:0];
					`UFTC_OFF_DIVL: divl_q <= pwdata[7:0];
					default: ;
				endcase
			end
			if (!enabled && !(wr_acc && paddr == `UFTC_OFF_CTRL1 && pwdata[`UFTC_C1_EN])) begin
				ctrl2_q[`UFTC_C2_TRANSMIT_ENABLE] <= 1'b0;
				ctrl2_q[`UFTC_C2_RECEIVE_ENABLE] <= 1'b0;
				ctrl1_q[`UFTC_C1_BRK] <= 1'b0;
			end
		end
	end

	// holding register and empty flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= `UFTC_RST_BYTE;
			hold_full_q <= 1'b0;
			hold_nine_q <= 1'b0;
			tx_empty_q <= 1'b1;
		end else if (!enabled) begin
			hold_full_q <= 1'b0;
			tx_empty_q <= 1'b1;
		end else begin
			if (data_take) begin
				hold_q <= pwdata[7:0];
				hold_nine_q <= ctrl1_q[`UFTC_C1_TX9];
				hold_full_q <= 1'b1;
			end else if (load_now) begin
				hold_full_q <= 1'b0;
			end
			// set by a move into the shifter wins over the clearing write
			if (load_now) begin
				tx_empty_q <= 1'b1;
			end else if (data_take && arm_q) begin
				tx_empty_q <= 1'b0;
			end
		end
	end

	// clear sequence arming
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_q <= 1'b0;
		end else if (status_rd) begin
			arm_q <= 1'b1;
		end else if (data_wr) begin
			arm_q <= 1'b0;
		end
	end

	// idle flags; frame end sets and wins over the clearing write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_idle_q <= 1'b1;
			rx_idle_q <= 1'b1;
		end else if (!enabled) begin
			tx_idle_q <= 1'b1;
			rx_idle_q <= 1'b1;
		end else if (frame_done) begin
			tx_idle_q <= 1'b1;
		end else if (data_take && arm_q) begin
			tx_idle_q <= 1'b0;
		end
	end

	// frame state; a dropped enable parks it at once, mid-bit or not
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= uftc_pkg::TX_IDLE;
		end else if (!tx_run) begin
			st_q <= uftc_pkg::TX_IDLE;
		end else if (load_now) begin
			st_q <= uftc_pkg::TX_START;
		end else if (bit_step) begin
			case (st_q)
				uftc_pkg::TX_START: begin
					st_q <= uftc_pkg::TX_DATA;
				end
				uftc_pkg::TX_DATA: begin
					if (last_data) begin
						st_q <= uftc_pkg::TX_STOP;
					end
				end
				uftc_pkg::TX_STOP: begin
					if (!stop2_q) begin
						st_q <= uftc_pkg::TX_IDLE;
					end
				end
				default: begin
					st_q <= uftc_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// frame snapshot; format frozen at load so control writes mid-frame do no harm
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frm_q <= '0;
		end else if (load_now) begin
			frm_q <= '{data: load_data, nbits: load_bits, two_stop: ctrl1_q[`UFTC_C1_TWOSTOP]};
		end else if (bit_step && st_q == uftc_pkg::TX_DATA) begin
			frm_q.data <= {1'b0, frm_q.data[8:1]};
		end
	end

	// data bit count within the frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_idx_q <= `UFTC_ACC_ZERO;
		end else if (load_now) begin
			bit_idx_q <= `UFTC_ACC_ZERO;
		end else if (bit_step && st_q == uftc_pkg::TX_DATA) begin
			bit_idx_q <= bit_idx_q + `UFTC_ONE4;
		end
	end

	// second stop bit pending; only the transmitter honours it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop2_q <= 1'b0;
		end else if (load_now) begin
			stop2_q <= 1'b0;
		end else if (bit_step && st_q == uftc_pkg::TX_DATA && last_data) begin
			stop2_q <= frm_q.two_stop;
		end else if (bit_step && st_q == uftc_pkg::TX_STOP) begin
			stop2_q <= 1'b0;
		end
	end

	// bit time counter; counts down to one, then the bit ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= `UFTC_RST_CNT;
		end else if (load_now) begin
			// start bit: a fresh accumulator cannot carry, so it is a plain divider
			cnt_q <= divider;
		end else if (bit_step) begin
			// carry into bit 3 stretches the next bit time by one clock
			cnt_q <= divider + {15'h0000, acc_sum[3]};
		end else if (tx_run && st_q != uftc_pkg::TX_IDLE) begin
			cnt_q <= cnt_q - `UFTC_ONE16;
		end
	end

	// modulation accumulator keeps only the fraction; restarts with each frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= `UFTC_ACC_ZERO;
		end else if (!tx_run) begin
			acc_q <= `UFTC_ACC_ZERO;
		end else if (load_now) begin
			acc_q <= {1'b0, modv};
		end else if (bit_step) begin
			acc_q <= {1'b0, acc_sum[2:0]};
		end
	end

	// pins: tx driven only while enabled, idles high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
			tx_oe <= 1'b0;
			rx_pin_claim <= 1'b0;
		end else begin
			tx_oe <= tx_run;
			rx_pin_claim <= enabled && ctrl2_q[`UFTC_C2_RECEIVE_ENABLE];
			if (!tx_run) begin
				// released pin rests high, never holding a stale data bit
				tx_out <= 1'b1;
			end else begin
				case (st_q)
					uftc_pkg::TX_START: tx_out <= 1'b0;
					uftc_pkg::TX_DATA: tx_out <= frm_q.data[0];
					default: tx_out <= 1'b1;
				endcase
			end
		end
	end

	// interrupt from empty and idle flags with their enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uart_irq <= 1'b0;
		end else begin
			uart_irq <= enabled && ((ctrl2_q[`UFTC_C2_TX_EMPTY_IRQ_ENABLE] && tx_empty_q) ||
				(ctrl2_q[`UFTC_C2_TIIE] && tx_idle_q));
		end
	end

	// read mux; receiver flags other than rx idle are absent so they read cleared; rx idle reads rx_idle_q
	always_comb begin
		rd_mux = `UFTC_ZERO32;
		case (paddr)
			`UFTC_OFF_STATUS: rd_mux[7:0] = {4'h0, rx_idle_q, 1'b0, tx_idle_q, tx_empty_q};
			`UFTC_OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
			`UFTC_OFF_CTRL2: rd_mux[7:0] = ctrl2_q;
			`UFTC_OFF_CTRL3: rd_mux[7:0] = ctrl3_q;
			`UFTC_OFF_DATA: rd_mux[7:0] = hold_q;
			`UFTC_OFF_DIVH: rd_mux[7:0] = divh_q;
			`UFTC_OFF_DIVL: rd_mux[7:0] = divl_q;
			`UFTC_OFF_FIFOCTL: rd_mux[7:0] = fifoctl_q;
			default: rd_mux = `UFTC_ZERO32;
		endcase
	end

	// apb answer registered: ready in the first access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= `UFTC_ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= rd_mux;
			end
		end
	end

endmodule
`default_nettype wire

// [include/uftc_params.svh]
// Purpose: register offsets, field positions, reset values and timing counts for the uart transmitter block
// Assumes: 32-bit apb, one aligned word per register
// Notes: definitions only
`ifndef UFTC_PARAMS_SVH
`define UFTC_PARAMS_SVH

`define UFTC_OFF_STATUS 12'h000
`define UFTC_OFF_CTRL1 12'h004
`define UFTC_OFF_CTRL2 12'h008
`define UFTC_OFF_CTRL3 12'h00C
`define UFTC_OFF_DATA 12'h010
`define UFTC_OFF_DIVH 12'h014
`define UFTC_OFF_DIVL 12'h018
`define UFTC_OFF_FIFOCTL 12'h01C
`define UFTC_OFF_RX_FIFO_COUNT 12'h020

// control one fields
`define UFTC_C1_EN 7
`define UFTC_C1_NINE 6
`define UFTC_C1_PAREN 5
`define UFTC_C1_PTYP_HI 4
`define UFTC_C1_PTYP_LO 3
`define UFTC_C1_TWOSTOP 2
`define UFTC_C1_BRK 1
`define UFTC_C1_TX9 0
// control two fields
`define UFTC_C2_TRANSMIT_ENABLE 7
`define UFTC_C2_RECEIVE_ENABLE 6
`define UFTC_C2_ADDR 3
`define UFTC_C2_TX_EMPTY_IRQ_ENABLE 2
`define UFTC_C2_TIIE 1
// status fields
`define UFTC_ST_PARITY_ERROR_FLAG 7
`define UFTC_ST_NF 6
`define UFTC_ST_FRAMING_FLAG 5
`define UFTC_ST_OVERRUN_FLAG 4
`define UFTC_ST_RX_IDLE_FLAG 3
`define UFTC_ST_RX_READY_FLAG 2
`define UFTC_ST_TX_IDLE_FLAG 1
`define UFTC_ST_TX_EMPTY_FLAG 0
// fifo control fields
`define UFTC_FC_MOD_HI 5
`define UFTC_FC_MOD_LO 3

`define UFTC_RST_BYTE 8'h00
`define UFTC_RST_DIV 16'h0000
`define UFTC_RST_CNT 16'h0001
`define UFTC_ONE16 16'h0001
`define UFTC_ACC_ZERO 4'h0
`define UFTC_BITS_8N1 4'h9
`define UFTC_BITS_8 4'h8
`define UFTC_ONE4 4'h1
`define UFTC_ZERO32 32'h0000_0000

`endif

// [include/uftc_pkg.sv]
// Purpose: shared types for the uart transmitter block
// Assumes: nothing beyond the params header
// Notes: states are one-hot
package uftc_pkg;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} uftc_tx_state_t;

	// frame layout snapshot taken at shift register load
	typedef struct packed {
		logic [8:0] data;
		logic [3:0] nbits;
		logic two_stop;
	} uftc_frame_t;
endpackage

// [tb/uftc_top_assertions.sv]
// Purpose: port checks of the uart transmitter block
// Assumes: divider of 2 or more
// Notes: bound to uftc_top
`timescale 1ns/1ns
`default_nettype none
module uftc_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_out,
	input wire logic tx_oe
);
	logic wr_seen;
	// a completed write access as the slave takes it
	assign wr_seen = psel && penable && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// apb phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	chk_ready_first: assert property (s_setup ##1 s_access |-> pready) else $error("no zero wait answer");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_cause: assert property (pready |-> psel && penable) else $error("pready outside access");
	chk_no_slverr: assert property (pready |-> !pslverr) else $error("slave error");
	chk_prdata_hold: assert property (!psel && !$past(psel) |-> $stable(prdata)) else $error("read data moved");
	chk_idle_high: assert property (!tx_oe |-> tx_out) else $error("released line low");
	chk_start_hold: assert property ($fell(tx_out) |=> !tx_out || !tx_oe) else $error("short start bit");
	chk_oe_cause: assert property ($changed(tx_oe) |-> $past(wr_seen, 2)) else $error("oe moved");
endmodule
bind uftc_top uftc_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe));
`default_nettype wire

// [tb/uftc_remote_rx.sv]
// Purpose: remote receiver on the transmit line
// Assumes: nominal bit time of DIV clocks
// Notes: always takes nine slots after the start bit
`timescale 1ns/1ns
`default_nettype none
module uftc_remote_rx #(
	parameter int DIV = 8
) (
	input wire logic clk,
	input wire logic line,
	output logic [8:0] word,
	output int frames,
	output int low_run
);
	int cnt;
	// mid-bit sampling, lsb first; ninth slot is the stop bit in 8-bit mode
	initial begin
		frames = 0;
		word = 9'h000;
		forever begin
			@(negedge line);
			repeat (DIV / 2) @(posedge clk);
			for (int k = 0; k < 9; k++) begin
				repeat (DIV) @(posedge clk);
				word[k] = line;
			end
			wait (line);
			frames++;
		end
	end
	// low run length shows stretched bit times
	always @(posedge clk) begin
		if (!line) begin
			cnt <= cnt + 1;
		end else begin
			if (cnt != 0) begin
				low_run <= cnt;
			end
			cnt <= 0;
		end
	end
endmodule
`default_nettype wire

// [tb/uftc_top_tb_top.sv]
// Purpose: self-checking bench of the uart transmitter block
// Assumes: pull-up on the line while released
// Notes: divider 8 keeps frames short
`timescale 1ns/1ns
`default_nettype none
`include "uftc_params.svh"
module uftc_top_tb_top;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tx_out, tx_oe, rx_pin_claim, uart_irq, line;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [8:0] word;
	logic [7:0] d;
	logic [7:0] cfg [10] = '{8'hA0, 8'hA8, 8'hB0, 8'hB8, 8'hC1, 8'hC0, 8'hE8, 8'hF1, 8'h84, 8'h80};
	int frames, low_run, n_mismatch, total_checks, f0;
	assign line = tx_oe ? tx_out : 1'h1;
	uftc_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe),
		.rx_pin_claim(rx_pin_claim), .uart_irq(uart_irq));
	uftc_remote_rx #(.DIV(8)) i_rx (.clk(clk), .line(line), .word(word), .frames(frames), .low_run(low_run));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	task automatic summarize();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; read data lands in r
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'h1 && i < 16);
		if (pready !== 1'h1) begin
			n_mismatch++;
			summarize();
		end
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic tx(input logic [7:0] v);
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		apb(1'h1, `UFTC_OFF_DATA, {24'h0, v});
	endtask
	task automatic wait_frame(input int n);
		int i;
		i = 0;
		while (frames < n && i < 4000) begin
			@(posedge clk);
			i++;
		end
		if (frames < n) begin
			n_mismatch++;
			summarize();
		end
	endtask
	// cut the link mid-frame by clearing the given enable
	task automatic abort(input logic [11:0] a);
		tx(8'h55);
		repeat (20) @(posedge clk);
		apb(1'h1, a, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(tx_oe), 32'h0);
		chk(32'(tx_out), 32'h1);
		repeat (100) @(posedge clk);
	endtask
	// ninth slot: stop bit, or control bit in nine-bit mode; parity takes the top slot
	function automatic logic [8:0] exp_word(input logic [7:0] c, input logic [7:0] v);
		logic [7:0] m;
		logic p;
		logic [8:0] w;
		m = c[6] ? v : {1'h0, v[6:0]};
		p = c[4] ? ~c[3] : (^m ^ c[3]);
		w = {c[6] ? c[0] : 1'h1, v};
		if (c[5]) begin
			w[c[6] ? 8 : 7] = p;
		end
		return w;
	endfunction
	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		void'($urandom(97679));
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, `UFTC_OFF_CTRL1, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		chk(r, 32'h0B);
		apb(1'h0, 12'h0FC, 32'h0);
		chk(r, 32'h0);
		apb(1'h1, `UFTC_OFF_DIVL, 32'h8);
		apb(1'h1, `UFTC_OFF_CTRL1, 32'h80);
		apb(1'h1, `UFTC_OFF_CTRL2, 32'h80);
		repeat (2) @(posedge clk);
		chk(32'(tx_oe), 32'h1);
		chk(32'(rx_pin_claim), 32'h0);
		// empty interrupt, receive claim and address detect on for the format sweep
		apb(1'h1, `UFTC_OFF_CTRL2, 32'hCC);
		repeat (2) @(posedge clk);
		chk(32'(uart_irq), 32'h1);
		chk(32'(rx_pin_claim), 32'h1);
		// every parity type, both lengths, random payloads
		foreach (cfg[j]) begin
			apb(1'h1, `UFTC_OFF_CTRL1, {24'h0, cfg[j]});
			d = 8'($urandom);
			f0 = frames;
			tx(d);
			wait_frame(f0 + 1);
			chk(32'(word), 32'(exp_word(cfg[j], d)));
		end
		apb(1'h1, `UFTC_OFF_CTRL2, 32'h80);
		repeat (2) @(posedge clk);
		chk(32'(uart_irq), 32'h0);
		// second byte held, armed write while full and unarmed write both dropped
		f0 = frames;
		tx(8'h3C);
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		chk(r, 32'h09);
		apb(1'h1, `UFTC_OFF_DATA, 32'hC3);
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		chk(r, 32'h08);
		apb(1'h1, `UFTC_OFF_DATA, 32'h5A);
		apb(1'h1, `UFTC_OFF_DATA, 32'h77);
		wait_frame(f0 + 1);
		chk(32'(word), 32'h13C);
		wait_frame(f0 + 2);
		chk(32'(word), 32'h1C3);
		repeat (200) @(posedge clk);
		chk(32'(frames), 32'(f0 + 2));
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		chk(r, 32'h0B);
		// modulation 3: start plus eight zero bits gain three clocks
		apb(1'h1, `UFTC_OFF_FIFOCTL, 32'h18);
		repeat (2) begin
			f0 = frames;
			tx(8'h00);
			wait_frame(f0 + 1);
			repeat (2) @(posedge clk);
			chk(32'(low_run), 32'h4B);
		end
		abort(`UFTC_OFF_CTRL2);
		apb(1'h1, `UFTC_OFF_CTRL2, 32'h80);
		abort(`UFTC_OFF_CTRL1);
		apb(1'h0, `UFTC_OFF_STATUS, 32'h0);
		chk(r, 32'h0B);
		apb(1'h0, `UFTC_OFF_CTRL2, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `UFTC_OFF_DIVL, 32'h0);
		chk(r, 32'h8);
		apb(1'h0, `UFTC_OFF_FIFOCTL, 32'h0);
		chk(r, 32'h18);
		summarize();
	end
endmodule
`default_nettype wire
